// ===== rtl/i2s_audio_port_config.v
// Summary of operation
// - Input clock-mode bit 7 clear: word select, bit clock and data are all inputs.
// - Bit 7 set: device drives word select and bit clock; source supplies data.
// - Input bits 5:4 pick 16 or 24-bit samples; bit 3 picks left polarity.
// - Input data valid on rising edge; bit 1 MSB delay; bit 0 justification.
// - Receiver audio port governed by mode register 0x4a and output format 0x44.
// - Mode register bit 7 powers the audio receiver down.
// - Mode bit 5 enables radio, bit 2 enables S/PDIF; other bits reserved.
// - Output bit 3 picks left polarity; bit 2 picks rising or falling valid edge.
// - Output bit 1 picks MSB delay; bit 0 picks left or right justification.
// - Mute bit 6 forces output samples to zero at once, no ramping.
// - A mute change acts immediately, without waiting for reconfiguration.
// - Other output changes wait until link mode bit 4 is written as one.
// - On link-locate the mode register contents are sent to the transmitter.
// - The remote transmitter reads and writes these registers over the control channel.
`timescale 1ns/10ps
`include "i2s_audio_port_defs.vh"

module i2s_audio_port_config #(
	parameter HALF_CYC = `BCLK_HALF_CYC,
	parameter DIV_W = 8,
	parameter BUF_DEPTH = 2
) (
	input wire clk,
	input wire rst_b,
	input wire [7:0] ctl_addr,
	input wire [7:0] ctl_wdata,
	input wire ctl_write,
	input wire ctl_read,
	output wire [7:0] ctl_rdata,
	input wire link_locate,
	output wire mode_report_valid,
	output wire [7:0] mode_report_data,
	output wire radio_enable,
	output wire spdif_enable,
	output wire rx_power_down,
	input wire in_bclk_i,
	output wire in_bclk_o,
	output wire in_bclk_oe,
	input wire in_ws_i,
	output wire in_ws_o,
	output wire in_ws_oe,
	input wire in_data_i,
	output wire in_sample_valid,
	input wire in_sample_ready,
	output wire [23:0] in_sample_data,
	output wire in_sample_left,
	input wire out_sample_valid,
	output wire out_sample_ready,
	input wire [23:0] out_sample_data,
	output wire out_bclk,
	output wire out_ws,
	output wire out_data
);

	// ==========================================================
	// Word extraction and bit selection helpers.
	// Samples are held MSB-aligned in 24 bits; 16-bit words sit in 23:8.
	function [23:0] pick_word;
		input [31:0] sh;
		input [5:0] n;
		input rj;
		input l24;
		reg [5:0] w;
		reg [31:0] t;
		begin
			w = l24 ? `BITS_24 : `BITS_16;
			if (rj || (n < w)) begin
				t = sh;
			end else begin
				t = sh >> (n - w);
			end
			pick_word = l24 ? t[23:0] : {t[15:0], 8'h00};
		end
	endfunction

	function out_bit;
		input [23:0] word;
		input [4:0] pos;
		input d1;
		input rj;
		input l24;
		reg [5:0] w;
		reg [5:0] off;
		reg [5:0] k;
		begin
			w = l24 ? `BITS_24 : `BITS_16;
			off = {5'h00, d1} + (rj ? (`SLOT_BITS - w) : 6'h00);
			k = {1'b0, pos} - off;
			if (({1'b0, pos} < off) || (k >= w)) begin
				out_bit = 1'b0;
			end else begin
				out_bit = word[5'd23 - k[4:0]];
			end
		end
	endfunction

	// ==========================================================
	// Registers.
	reg [7:0] in_fmt_ff;
	reg [7:0] mode_ff;
	reg [7:0] out_fmt_ff;
	reg [7:0] out_act_ff;
	reg [7:0] link_mode_ff;
	reg [7:0] rdata_ff;
	reg overrun_ff;
	reg report_v_ff;
	reg [7:0] report_d_ff;
	wire wr_in;
	wire wr_mode;
	wire wr_out;
	wire wr_link;
	wire wr_stat;
	wire reconf;
	wire in_master;
	wire pdn;
	wire [7:0] status;

	assign wr_in = ctl_write && (ctl_addr == `ADDR_IN_FMT);
	assign wr_mode = ctl_write && (ctl_addr == `ADDR_MODE);
	assign wr_out = ctl_write && (ctl_addr == `ADDR_OUT_FMT);
	assign wr_link = ctl_write && (ctl_addr == `ADDR_LINK_MODE);
	assign wr_stat = ctl_write && (ctl_addr == `ADDR_STATUS);
	assign reconf = wr_link && ctl_wdata[`LINK_RECONF];
	assign in_master = in_fmt_ff[`IN_MASTER];
	assign pdn = mode_ff[`MODE_PDN];
	assign status = {5'h00, in_master, (out_fmt_ff[3:0] != out_act_ff[3:0]), overrun_ff};

	// Control-channel register file; reserved bits are masked so they read zero.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			in_fmt_ff <= `REG_RST;
			mode_ff <= `REG_RST;
			out_fmt_ff <= `REG_RST;
			out_act_ff <= `REG_RST;
			link_mode_ff <= `REG_RST;
			rdata_ff <= `REG_RST;
		end else begin
			if (wr_in) begin
				in_fmt_ff <= ctl_wdata & `IN_FMT_MASK;
			end
			if (wr_mode) begin
				mode_ff <= ctl_wdata & `MODE_MASK;
			end
			if (wr_out) begin
				out_fmt_ff <= ctl_wdata & `OUT_FMT_MASK;
			end
			if (wr_link) begin
				link_mode_ff <= ctl_wdata & `LINK_MODE_MASK;
			end
			// The format used by the serializer only moves on a reconfiguration.
			if (reconf) begin
				out_act_ff <= wr_out ? (ctl_wdata & `OUT_FMT_MASK) : out_fmt_ff;
			end
			if (ctl_read) begin
				case (ctl_addr)
					`ADDR_IN_FMT: rdata_ff <= in_fmt_ff;
					`ADDR_MODE: rdata_ff <= mode_ff;
					`ADDR_OUT_FMT: rdata_ff <= out_fmt_ff;
					`ADDR_LINK_MODE: rdata_ff <= link_mode_ff;
					`ADDR_STATUS: rdata_ff <= status;
					default: rdata_ff <= `REG_RST;
				endcase
			end
		end
	end

	// Mode report toward the transmitter during link-locate.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			report_v_ff <= 1'b0;
			report_d_ff <= `REG_RST;
		end else begin
			report_v_ff <= link_locate;
			if (link_locate) begin
				report_d_ff <= mode_ff;
			end
		end
	end

	assign ctl_rdata = rdata_ff;
	assign mode_report_valid = report_v_ff;
	assign mode_report_data = report_d_ff;
	assign radio_enable = mode_ff[`MODE_RF];
	assign spdif_enable = mode_ff[`MODE_SPDIF];
	assign rx_power_down = mode_ff[`MODE_PDN];

	// ==========================================================
	// Bit clock and word select generator; its bit clock drives the output port, and the input port in master mode.
	reg [DIV_W-1:0] div_ff;
	reg gen_bclk_ff;
	reg gen_ws_ff;
	reg [4:0] gen_pos_ff;
	wire tick;
	wire rise_gen;
	wire fall_gen;

	assign tick = (div_ff == HALF_CYC[DIV_W-1:0] - 1'b1);
	assign rise_gen = tick & ~gen_bclk_ff;
	assign fall_gen = tick & gen_bclk_ff;

	// Word select changes on a falling edge once per slot.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_ff <= {DIV_W{1'b0}};
			gen_bclk_ff <= 1'b0;
			gen_ws_ff <= 1'b0;
			gen_pos_ff <= 5'h00;
		end else begin
			div_ff <= tick ? {DIV_W{1'b0}} : div_ff + 1'b1;
			if (tick) begin
				gen_bclk_ff <= ~gen_bclk_ff;
			end
			if (fall_gen) begin
				gen_pos_ff <= gen_pos_ff + 5'h01;
				if (gen_pos_ff == `SLOT_LAST) begin
					gen_ws_ff <= ~gen_ws_ff;
				end
			end
		end
	end

	assign in_bclk_o = gen_bclk_ff;
	assign in_ws_o = gen_ws_ff;
	assign in_bclk_oe = in_master;
	assign in_ws_oe = in_master;

	// ==========================================================
	// Input capture: pins pass two flops; the generated clock is delayed to match.
	reg bclk_s1, bclk_s2, ws_s1, ws_s2, dat_s1, dat_s2;
	reg gb_d1, gb_d2, gw_d1, gw_d2;
	reg prev_bclk_ff;
	reg prev_ws_ff;
	reg [31:0] sh_ff;
	reg [5:0] cnt_ff;
	reg seen_ff;
	wire src_bclk;
	wire src_ws;
	wire rise;
	wire ws_chg;
	wire delay1;
	wire [31:0] full_sh;
	wire [5:0] full_cnt;
	wire [5:0] cnt_inc;
	wire push;
	wire buf_ready;
	wire [24:0] push_data;

	assign src_bclk = in_master ? gb_d2 : bclk_s2;
	assign src_ws = in_master ? gw_d2 : ws_s2;
	assign rise = src_bclk & ~prev_bclk_ff;
	assign ws_chg = rise && (src_ws != prev_ws_ff);
	assign delay1 = ~in_fmt_ff[`IN_DELAY0];
	assign cnt_inc = (cnt_ff == `SLOT_BITS) ? cnt_ff : cnt_ff + 6'h01;
	assign full_sh = delay1 ? {sh_ff[30:0], dat_s2} : sh_ff;
	assign full_cnt = delay1 ? cnt_inc : cnt_ff;
	assign push = ws_chg && seen_ff;
	assign push_data = {(prev_ws_ff == in_fmt_ff[`IN_WS_POL]),
		pick_word(full_sh, full_cnt, in_fmt_ff[`IN_RJ],
		in_fmt_ff[`IN_LEN_HI:`IN_LEN_LO] == `LEN_24)};

	// Synchronizers and capture shifter; the first partial word is dropped.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{bclk_s1, bclk_s2, ws_s1, ws_s2, dat_s1, dat_s2} <= 6'h00;
			{gb_d1, gb_d2, gw_d1, gw_d2} <= 4'h0;
			prev_bclk_ff <= 1'b0;
			prev_ws_ff <= 1'b0;
			sh_ff <= 32'h0000_0000;
			cnt_ff <= 6'h00;
			seen_ff <= 1'b0;
			overrun_ff <= 1'b0;
		end else begin
			bclk_s1 <= in_bclk_i;
			bclk_s2 <= bclk_s1;
			ws_s1 <= in_ws_i;
			ws_s2 <= ws_s1;
			dat_s1 <= in_data_i;
			dat_s2 <= dat_s1;
			gb_d1 <= gen_bclk_ff;
			gb_d2 <= gb_d1;
			gw_d1 <= gen_ws_ff;
			gw_d2 <= gw_d1;
			prev_bclk_ff <= src_bclk;
			if (rise) begin
				prev_ws_ff <= src_ws;
				if (ws_chg) begin
					seen_ff <= 1'b1;
					sh_ff <= delay1 ? 32'h0000_0000 : {31'h0000_0000, dat_s2};
					cnt_ff <= delay1 ? 6'h00 : 6'h01;
				end else begin
					sh_ff <= {sh_ff[30:0], dat_s2};
					cnt_ff <= cnt_inc;
				end
			end
			// A new overrun wins over a clear in the same cycle.
			if (push && !buf_ready) begin
				overrun_ff <= 1'b1;
			end else if (wr_stat && ctl_wdata[`ST_OVERRUN]) begin
				overrun_ff <= 1'b0;
			end
		end
	end

	// The serial source cannot stall, so the buffer absorbs reader hiccups.
	audio_sample_buffer #(
		.WIDTH(25),
		.DEPTH(BUF_DEPTH),
		.CNT_W(2)
	) u_in_buf (
		.clk(clk),
		.rst_b(rst_b),
		.wr_valid(push),
		.wr_ready(buf_ready),
		.wr_data(push_data),
		.rd_valid(in_sample_valid),
		.rd_ready(in_sample_ready),
		.rd_data({in_sample_left, in_sample_data})
	);

	// ==========================================================
	// Output serializer, on the generated clock; shift edge opposes valid edge.
	reg [4:0] ob_pos_ff;
	reg ob_left_ff;
	reg [23:0] cur_ff;
	reg [23:0] hold_ff;
	reg oready_ff;
	reg obclk_ff;
	reg ows_ff;
	reg odat_ff;
	wire shift_evt;
	wire load;
	wire [4:0] nxt_pos;
	wire nxt_left;
	wire [23:0] nxt_word;
	wire take;

	assign shift_evt = out_act_ff[`OUT_FALL] ? rise_gen : fall_gen;
	assign load = shift_evt && (ob_pos_ff == `SLOT_LAST);
	assign nxt_pos = ob_pos_ff + 5'h01;
	assign nxt_left = load ? ~ob_left_ff : ob_left_ff;
	assign nxt_word = load ? hold_ff : cur_ff;
	assign take = out_sample_valid && oready_ff;

	// Port is held quiet while powered down; mute clears data every cycle.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ob_pos_ff <= `SLOT_LAST;
			ob_left_ff <= 1'b0;
			cur_ff <= 24'h00_0000;
			hold_ff <= 24'h00_0000;
			oready_ff <= 1'b1;
			obclk_ff <= 1'b0;
			ows_ff <= 1'b0;
			odat_ff <= 1'b0;
		end else if (pdn) begin
			ob_pos_ff <= `SLOT_LAST;
			ob_left_ff <= 1'b0;
			obclk_ff <= 1'b0;
			ows_ff <= 1'b0;
			odat_ff <= 1'b0;
		end else begin
			obclk_ff <= tick ? ~gen_bclk_ff : gen_bclk_ff;
			if (shift_evt) begin
				ob_pos_ff <= nxt_pos;
				ob_left_ff <= nxt_left;
				cur_ff <= nxt_word;
				ows_ff <= nxt_left ? out_act_ff[`OUT_WS_POL] : ~out_act_ff[`OUT_WS_POL];
			end
			if (out_fmt_ff[`OUT_MUTE]) begin
				odat_ff <= 1'b0;
			end else if (shift_evt) begin
				odat_ff <= out_bit(nxt_word, nxt_pos, ~out_act_ff[`OUT_DELAY0],
					out_act_ff[`OUT_RJ], 1'b1);
			end
			// Underrun plays silence rather than repeating a stale word.
			if (take) begin
				hold_ff <= out_sample_data;
				oready_ff <= 1'b0;
			end else if (load) begin
				hold_ff <= 24'h00_0000;
				oready_ff <= 1'b1;
			end
		end
	end

	assign out_sample_ready = oready_ff;
	assign out_bclk = obclk_ff;
	assign out_ws = ows_ff;
	assign out_data = odat_ff;

endmodule

// ===== rtl/i2s_audio_port_defs.vh
`ifndef I2S_AUDIO_PORT_DEFS_VH
`define I2S_AUDIO_PORT_DEFS_VH

// ==========================================================
// Register offsets on the control channel
`define ADDR_OUT_FMT 8'h44
`define ADDR_MODE 8'h4a
`define ADDR_IN_FMT 8'h54
`define ADDR_LINK_MODE 8'h59
`define ADDR_STATUS 8'h5f

// ==========================================================
// Reset value and writable-bit masks (reserved bits stay zero)
`define REG_RST 8'h00
`define IN_FMT_MASK 8'hbf
`define MODE_MASK 8'ha4
`define OUT_FMT_MASK 8'h4f
`define LINK_MODE_MASK 8'hef

// ==========================================================
// Field positions
`define IN_MASTER 7
`define IN_LEN_HI 5
`define IN_LEN_LO 4
`define IN_WS_POL 3
`define IN_DELAY0 1
`define IN_RJ 0
`define MODE_PDN 7
`define MODE_RF 5
`define MODE_SPDIF 2
`define OUT_MUTE 6
`define OUT_WS_POL 3
`define OUT_FALL 2
`define OUT_DELAY0 1
`define OUT_RJ 0
`define LINK_RECONF 4
`define ST_OVERRUN 0
`define ST_PENDING 1
`define ST_MASTER 2

// ==========================================================
// Sample length codes and word widths
`define LEN_24 2'b10
`define BITS_24 6'd24
`define BITS_16 6'd16
`define SLOT_BITS 6'd32
`define SLOT_LAST 5'd31

// ==========================================================
// Timing: system clock and generated bit clock
`define CLK_PERIOD_NS 100
`define BCLK_PERIOD_NS 800
`define BCLK_HALF_CYC (`BCLK_PERIOD_NS / (2 * `CLK_PERIOD_NS))

`endif

// ===== rtl/audio_sample_buffer.v
`timescale 1ns/10ps
`include "i2s_audio_port_defs.vh"

// Shift-style buffer: the head entry is always mem[0], so the read side
// sees data straight from a flop.
module audio_sample_buffer #(
	parameter WIDTH = 25,
	parameter DEPTH = 2,
	parameter CNT_W = 2
) (
	input wire clk,
	input wire rst_b,
	input wire wr_valid,
	output wire wr_ready,
	input wire [WIDTH-1:0] wr_data,
	output wire rd_valid,
	input wire rd_ready,
	output wire [WIDTH-1:0] rd_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [CNT_W-1:0] cnt_ff;
	reg valid_ff;
	wire push;
	wire pop;
	wire [CNT_W-1:0] nxt_cnt;
	integer i;

	// ==========================================================
	// Handshakes and occupancy.
	assign pop = valid_ff & rd_ready;
	assign wr_ready = (cnt_ff < DEPTH);
	assign push = wr_valid & wr_ready;
	assign nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, push} - {{(CNT_W-1){1'b0}}, pop};
	assign rd_valid = valid_ff;
	assign rd_data = mem[0];

	// Entries move down on a pop; a push lands just above the survivors.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= {WIDTH{1'b0}};
			end
			cnt_ff <= {CNT_W{1'b0}};
			valid_ff <= 1'b0;
		end else begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				if (push && (i == cnt_ff - pop)) begin
					mem[i] <= wr_data;
				end else if (pop && (i < DEPTH - 1)) begin
					mem[i] <= mem[i+1];
				end
			end
			cnt_ff <= nxt_cnt;
			valid_ff <= (nxt_cnt != {CNT_W{1'b0}});
		end
	end

endmodule

// ===== sim/i2s_audio_port_config_assertions.sv
`timescale 1ns/10ps
// ============================================================
// Port checker for the audio port configuration block
module i2s_audio_port_config_assertions #(
	parameter HALF_CYC = 4
) (
	input wire clk,
	input wire rst_b,
	input wire [7:0] ctl_addr,
	input wire [7:0] ctl_wdata,
	input wire ctl_write,
	input wire ctl_read,
	input wire [7:0] ctl_rdata,
	input wire link_locate,
	input wire mode_report_valid,
	input wire [7:0] mode_report_data,
	input wire radio_enable,
	input wire spdif_enable,
	input wire rx_power_down,
	input wire in_bclk_o,
	input wire in_bclk_oe,
	input wire in_ws_oe,
	input wire out_data
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Mode register image rebuilt from the enable outputs; reserved bits read zero.
	wire [7:0] mode_img = {rx_power_down, 1'b0, radio_enable, 2'b00, spdif_enable, 2'b00};
	wire wr_mode = ctl_write && ctl_addr == 8'h4a;
	reg [7:0] wd_ff;
	reg [7:0] hi_ff;
	// Last write data, and the length of the current high phase of the bit clock.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_ff <= 8'h00;
			hi_ff <= 8'h00;
		end else begin
			wd_ff <= ctl_wdata;
			hi_ff <= in_bclk_o ? hi_ff + 8'h01 : 8'h00;
		end
	end
	sequence s_report;
		mode_report_valid ##1 !mode_report_valid;
	endsequence
	sequence s_mute_hold;
		##2 !out_data [*8];
	endsequence
	a_mode_readback: assert property (ctl_read && !ctl_write && ctl_addr == 8'h4a
		|=> ctl_rdata == mode_img) else $error("Mode readback wrong.");
	a_pdn_update: assert property (wr_mode |=> rx_power_down == wd_ff[7])
		else $error("Power down not updated.");
	a_enable_update: assert property (wr_mode |=>
		{radio_enable, spdif_enable} == {wd_ff[5], wd_ff[2]}) else $error("Enables not updated.");
	a_report_pulse: assert property (link_locate |=> s_report)
		else $error("Report pulse wrong.");
	a_report_data: assert property (link_locate |=> mode_report_data == $past(mode_img))
		else $error("Report data wrong.");
	a_oe_pair: assert property (in_bclk_oe == in_ws_oe)
		else $error("Pin enables differ.");
	a_oe_cause: assert property ($changed(in_bclk_oe) |->
		$past(ctl_write) && $past(ctl_addr) == 8'h54) else $error("Enable moved alone.");
	a_bclk_half: assert property (in_bclk_oe && $fell(in_bclk_o) |-> hi_ff == HALF_CYC)
		else $error("Bit clock high phase wrong.");
	a_mute_silent: assert property (ctl_write && ctl_addr == 8'h44 && ctl_wdata[6]
		|-> s_mute_hold) else $error("Muted output not zero.");
endmodule

bind i2s_audio_port_config i2s_audio_port_config_assertions #(.HALF_CYC(HALF_CYC)) i_chk (.*);

// ===== sim/audio_source_model.sv
`timescale 1ns/10ps
// ============================================================
// External serial audio source; its bit clock stands still between frames
module audio_source_model (
	output logic bclk,
	output logic ws,
	output logic data
);
	logic last_ff = 1'b0;
	initial begin
		bclk = 1'b0;
		ws = 1'b1;
		data = 1'b0;
	end
	// One 32-bit slot; data moves on the falling edge so it is valid at the rising one.
	task automatic play_slot(input logic [31:0] w, input logic lvl, input logic d0);
		integer b;
		logic [32:0] v;
		v = {last_ff, w};
		#37;
		for (b = 0; b < 32; b++) begin
			bclk = 1'b0;
			ws = lvl;
			data = d0 ? v[31 - b] : v[32 - b];
			#400 bclk = 1'b1;
			#400;
		end
		last_ff = w[0];
	endtask
	// Closing bit marks the last word; afterwards the released data line is inverted.
	task automatic end_frame;
		#37 bclk = 1'b0;
		ws = ~ws;
		data = last_ff;
		#400 bclk = 1'b1;
		#400 bclk = 1'b0;
		data = ~data;
	endtask
endmodule

// ===== sim/tb_i2s_audio_port_config.sv
`timescale 1ns/10ps
// ============================================================
// Register-level bench for the audio port configuration block
module tb_i2s_audio_port_config;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] ctl_addr = 8'h00;
	logic [7:0] ctl_wdata = 8'h00;
	logic ctl_write = 1'b0;
	logic ctl_read = 1'b0;
	logic link_locate = 1'b0;
	logic in_sample_ready = 1'b0;
	logic out_sample_valid = 1'b0;
	logic feed_on = 1'b0;
	logic [23:0] out_sample_data = 24'hffffff;
	wire [7:0] ctl_rdata, mode_report_data;
	wire [23:0] in_sample_data;
	wire mode_report_valid, radio_enable, spdif_enable, rx_power_down, in_bclk_o, in_bclk_oe;
	wire in_ws_o, in_ws_oe, in_sample_valid, in_sample_left, out_sample_ready, out_bclk;
	wire out_ws, out_data, src_bclk, src_ws, in_data_i, in_bclk_i, in_ws_i;
	integer checked = 0, bad_count = 0, ones = 0, hi_b = 0, hi_w = 0, n0, b0, w0, i, k, n, c;
	logic [7:0] adr [5] = '{8'h44, 8'h4a, 8'h54, 8'h59, 8'h10};
	// Configuration registers only ever get legal codes with reserved bits at zero.
	logic [7:0] wv [5] = '{8'h4f, 8'ha4, 8'hab, 8'hff, 8'hff};
	logic [7:0] msk [5] = '{8'h4f, 8'ha4, 8'hab, 8'hef, 8'h00};
	logic [7:0] cfg [2] = '{8'h00, 8'h2b};
	logic [23:0] s [3] = '{24'ha5c3e1, 24'h5a3c1e, 24'h123456};

	i2s_audio_port_config i_dut (.*);
	audio_source_model i_src (.bclk(src_bclk), .ws(src_ws), .data(in_data_i));

	// The pin level follows whichever party drives it.
	assign in_bclk_i = in_bclk_oe ? in_bclk_o : src_bclk;
	assign in_ws_i = in_ws_oe ? in_ws_o : src_ws;

	initial begin
		forever #50 clk = ~clk;
	end

	// Full-scale words keep the serial output busy, so silence can only come from muting.
	// The high samples of the bit clock and word select are tallied as well.
	always @(posedge clk) begin
		out_sample_valid <= feed_on;
		ones <= ones + (out_data ? 1 : 0);
		hi_b <= hi_b + (out_bclk ? 1 : 0);
		hi_w <= hi_w + (out_ws ? 1 : 0);
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		ctl_addr <= a;
		ctl_wdata <= d;
		ctl_write <= 1'b1;
		@(posedge clk);
		ctl_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
		ctl_addr <= a;
		ctl_read <= 1'b1;
		@(posedge clk);
		ctl_read <= 1'b0;
		@(posedge clk);
		check("ctl_rdata", 32'(ctl_rdata), 32'(exp));
	endtask

	// Takes the head word; sampled at the falling edge where it has settled.
	task automatic pop(input logic chk, input logic [23:0] d, input logic left);
		@(negedge clk);
		for (n = 0; n < 400 && in_sample_valid !== 1'b1; n++) @(negedge clk);
		if (chk) check("in_sample", 32'({in_sample_valid, in_sample_left, in_sample_data}),
			32'({1'b1, left, d}));
		@(posedge clk);
		in_sample_ready <= 1'b1;
		@(posedge clk);
		in_sample_ready <= 1'b0;
	endtask

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// A hang is cut short well after the expected few thousand cycles.
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		// Reset values, legal full settings and an unmapped address.
		for (i = 0; i < 5; i++) begin
			reg_read(adr[i], 8'h00);
			reg_write(adr[i], wv[i]);
			reg_read(adr[i], msk[i]);
		end
		check("flags", 32'({rx_power_down, radio_enable, spdif_enable}), 32'h7);
		check("oe", 32'({in_bclk_oe, in_ws_oe}), 32'h3);
		reg_read(8'h5f, 8'h04);
		// Leave master mode in a low phase so the clock never stops mid-pulse.
		repeat (30) @(posedge clk);
		@(negedge in_bclk_o);
		@(posedge clk);
		reg_write(8'h54, 8'h00);
		check("oe", 32'({in_bclk_oe, in_ws_oe}), 32'h0);
		reg_write(8'h4a, 8'h20);
		check("flags", 32'({rx_power_down, radio_enable, spdif_enable}), 32'h2);
		// Format changes wait for the reconfiguration trigger.
		reg_write(8'h44, 8'h00);
		reg_read(8'h5f, 8'h02);
		reg_write(8'h59, 8'h10);
		reg_read(8'h5f, 8'h00);
		feed_on <= 1'b1;
		repeat (100) @(posedge clk);
		n0 = ones;
		b0 = hi_b;
		w0 = hi_w;
		// Two whole slots: the bit clock and word select are each high for exactly half.
		repeat (512) @(posedge clk);
		check("out_active", 32'(ones != n0), 32'h1);
		check("out_bclk", 32'(hi_b - b0), 32'h100);
		check("out_ws", 32'(hi_w - w0), 32'h100);
		reg_write(8'h44, 8'h40);
		repeat (3) @(posedge clk);
		n0 = ones;
		repeat (600) @(posedge clk);
		check("out_muted", 32'(ones - n0), 32'h0);
		feed_on <= 1'b0;
		reg_write(8'h44, 8'h00);
		// The report pulse stands for one cycle only, so it is looked at mid-cycle.
		link_locate <= 1'b1;
		@(posedge clk);
		link_locate <= 1'b0;
		@(negedge clk);
		check("report", 32'({mode_report_valid, mode_report_data}), 32'h120);
		@(posedge clk);
		// Each format: a lead slot, then words; the stalled consumer forces one drop in the first.
		for (c = 0; c < 2; c++) begin
			reg_write(8'h54, cfg[c]);
			i_src.play_slot(32'h0, 1'b1, cfg[c][1]);
			for (k = 0; k < 3 - c; k++) begin
				i_src.play_slot(c ? {8'h00, s[k]} : {s[k][23:8], 16'h0000}, k[0], cfg[c][1]);
				if (k == 0 && in_sample_valid === 1'b1) pop(1'b0, 24'h0, 1'b0);
			end
			i_src.end_frame();
			repeat (8) @(posedge clk);
			reg_read(8'h5f, c ? 8'h00 : 8'h01);
			for (k = 0; k < 2; k++) pop(1'b1, c ? s[k] : {s[k][23:8], 8'h00}, k[0] == cfg[c][3]);
			reg_write(8'h5f, 8'h01);
		end
		print_verdict();
	end
endmodule
